// ===== hdl/usfb_pkg.sv
`default_nettype none
package usfb_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam logic [13:0] IDX_STEP_MODE = 14'h205b;
   localparam logic [13:0] IDX_POLE_COMP = 14'h2060;
   localparam logic [13:0] IDX_VEL_NUM = 14'h2061;
   localparam logic [13:0] IDX_VEL_DEN = 14'h2062;
   localparam logic [13:0] IDX_ACC_NUM = 14'h2063;
   localparam logic [13:0] IDX_ACC_DEN = 14'h2064;
   localparam logic [13:0] IDX_JERK_NUM = 14'h2065;
   localparam logic [13:0] IDX_JERK_DEN = 14'h2066;
   localparam logic [13:0] IDX_BOOT_DELAY = 14'h2084;
   localparam logic [13:0] IDX_AVAIL = 14'h2101;
   localparam logic [13:0] IDX_CONTROL = 14'h2102;
   localparam logic [13:0] IDX_ACTIVE = 14'h2103;
   localparam logic [13:0] IDX_SW_MASK = 14'h2104;
   localparam logic [13:0] IDX_STAT_COUNT = 14'h2105;
   localparam logic [13:0] IDX_SCALE_STAT = 14'h2106;
   localparam logic [31:0] RST_STEP_MODE = 32'h0000_0000;
   localparam logic [31:0] RST_POLE_COMP = 32'h0000_0001;
   localparam logic [31:0] RST_NUM = 32'h0000_0001;
   localparam logic [31:0] RST_DEN = 32'h0000_003c;
   localparam logic [31:0] RST_BOOT_DELAY = 32'h0000_0000;
   localparam logic [31:0] RST_AVAIL = 32'h0000_0040;
   localparam logic [31:0] RST_CONTROL = 32'h0000_0040;
   localparam logic [31:0] RST_SW_MASK = 32'h0000_0000;
   localparam logic [31:0] STAT_COUNT = 32'h0000_0002;
   localparam logic [31:0] MODE_CLK_DIR = 32'h0000_0000;
   localparam logic [31:0] MODE_CW_CCW = 32'h0000_0001;
   localparam logic [31:0] COMP_ON = 32'h0000_0001;
   localparam int unsigned USB_BIT = 0;
   localparam int unsigned RS485_BIT = 1;
   localparam int unsigned RS232_BIT = 2;
   localparam int unsigned CAN_BIT = 3;
   localparam int unsigned ETHERNET_PORT_BIT = 4;
   localparam int unsigned INDUSTRIAL_ETHER_BIT = 5;
   localparam int unsigned SPI_BIT = 6;
   localparam int unsigned SERIAL_MODBUS_BIT = 16;
   localparam int unsigned TCP_MODBUS_BIT = 17;
   localparam int unsigned INDUSTRIAL_IP_BIT = 18;
   localparam int unsigned PHY_LSB = 0;
   localparam int unsigned PHY_MSB = 15;
   localparam int unsigned PROTO_LSB = 16;
   localparam int unsigned PROTO_MSB = 31;
   localparam int unsigned SCALE_STEPS = 64;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned BOOT_UNIT_MS = 1;
   localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S * BOOT_UNIT_MS;
   localparam logic [1:0] KIND_VEL = 2'h0;
   localparam logic [1:0] KIND_ACC = 2'h1;
   localparam logic [1:0] KIND_JERK = 2'h2;
   typedef enum logic [2:0] {
      SC_IDLE = 3'b001,
      SC_MUL = 3'b010,
      SC_DIV = 3'b100
   } usfb_scale_t;
endpackage : usfb_pkg
`default_nettype wire

// ===== hdl/usfb_bank.sv
`default_nettype none
module usfb_bank #(
   parameter int unsigned MS_CYCLES = usfb_pkg::CYCLES_PER_MS,
   parameter logic [31:0] AVAIL_MAP = usfb_pkg::RST_AVAIL,
   parameter logic [31:0] SW_MASK = usfb_pkg::RST_SW_MASK,
   parameter int unsigned PP_W = 8
) (
   input wire logic mclk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic [usfb_pkg::ADDR_W-1:0] addr, // byte address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd
   input wire logic step_a, // clock or cw pulse pin
   input wire logic step_b, // direction or ccw pulse pin
   output logic step_pulse, // one step taken
   output logic step_cw, // direction of last step
   input wire logic [PP_W-1:0] pole_pairs, // motor pole-pair count
   input wire logic scale_start, // start a conversion
   input wire logic [1:0] scale_kind, // vel, acc or jerk
   input wire logic [31:0] scale_in, // user-unit value
   output logic scale_busy, // conversion running
   output logic scale_done, // result valid pulse
   output logic [31:0] scale_out, // internal-unit result
   output logic scale_err, // zero denominator
   output logic scale_ovf, // result exceeds 32 bits
   output logic ready, // functional readiness
   output logic [31:0] bus_active // active fieldbuses
);
   logic rst_q1;
   logic rst_q2;
   logic rst_n;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end
   assign rst_n = rst_q2;

   logic [13:0] idx;
   logic [31:0] step_mode;
   logic [31:0] pole_comp;
   logic [31:0] num [3];
   logic [31:0] den [3];
   logic [31:0] boot_delay;
   logic [31:0] control;
   logic [31:0] active;
   assign idx = addr[15:2];

   function automatic logic [1:0] num_sel(input logic [13:0] i);
      case (i)
         usfb_pkg::IDX_VEL_NUM: num_sel = 2'h1;
         usfb_pkg::IDX_ACC_NUM: num_sel = 2'h2;
         usfb_pkg::IDX_JERK_NUM: num_sel = 2'h3;
         default: num_sel = 2'h0;
      endcase
   endfunction : num_sel

   function automatic logic [1:0] den_sel(input logic [13:0] i);
      case (i)
         usfb_pkg::IDX_VEL_DEN: den_sel = 2'h1;
         usfb_pkg::IDX_ACC_DEN: den_sel = 2'h2;
         usfb_pkg::IDX_JERK_DEN: den_sel = 2'h3;
         default: den_sel = 2'h0;
      endcase
   endfunction : den_sel

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         step_mode <= usfb_pkg::RST_STEP_MODE;
         pole_comp <= usfb_pkg::RST_POLE_COMP;
         boot_delay <= usfb_pkg::RST_BOOT_DELAY;
         control <= usfb_pkg::RST_CONTROL;
      end else if (wr) begin
         if (idx == usfb_pkg::IDX_STEP_MODE) begin
            step_mode <= wdata;
         end
         if (idx == usfb_pkg::IDX_POLE_COMP) begin
            pole_comp <= wdata;
         end
         if (idx == usfb_pkg::IDX_BOOT_DELAY) begin
            boot_delay <= wdata;
         end
         if (idx == usfb_pkg::IDX_CONTROL) begin
            control <= wdata;
         end
      end
   end

   // three scale pairs share one decode
   for (genvar k = 0; k < 3; k++) begin : g_pair
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            num[k] <= usfb_pkg::RST_NUM;
            den[k] <= usfb_pkg::RST_DEN;
         end else if (wr) begin
            if (num_sel(idx) == 2'(k + 1)) begin
               num[k] <= wdata;
            end
            if (den_sel(idx) == 2'(k + 1)) begin
               den[k] <= wdata;
            end
         end
      end
   end

   // bits that name no bus can never be switched on
   localparam logic [31:0] BUS_BITS = (32'h1 << usfb_pkg::USB_BIT)
      | (32'h1 << usfb_pkg::RS485_BIT)
      | (32'h1 << usfb_pkg::RS232_BIT)
      | (32'h1 << usfb_pkg::CAN_BIT)
      | (32'h1 << usfb_pkg::ETHERNET_PORT_BIT)
      | (32'h1 << usfb_pkg::INDUSTRIAL_ETHER_BIT)
      | (32'h1 << usfb_pkg::SPI_BIT)
      | (32'h1 << usfb_pkg::SERIAL_MODBUS_BIT)
      | (32'h1 << usfb_pkg::TCP_MODBUS_BIT)
      | (32'h1 << usfb_pkg::INDUSTRIAL_IP_BIT);
   localparam logic [31:0] SW_LIVE = SW_MASK & AVAIL_MAP & BUS_BITS;

   // active state: non-switchable bits and absent buses never move
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         active <= usfb_pkg::RST_CONTROL;
      end else if (wr && idx == usfb_pkg::IDX_CONTROL) begin
         active <= (active & ~SW_MASK) | (wdata & SW_LIVE);
      end
   end
   assign bus_active = active;

   logic [31:0] scale_stat;
   assign scale_stat = {29'h0, scale_ovf, scale_err, scale_busy};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0;
      end else if (rd) begin
         if (num_sel(idx) != 2'h0) begin
            rdata <= num[num_sel(idx) - 2'h1];
         end else if (den_sel(idx) != 2'h0) begin
            rdata <= den[den_sel(idx) - 2'h1];
         end else begin
            unique case (idx)
               usfb_pkg::IDX_STEP_MODE: rdata <= step_mode;
               usfb_pkg::IDX_POLE_COMP: rdata <= pole_comp;
               usfb_pkg::IDX_BOOT_DELAY: rdata <= boot_delay;
               usfb_pkg::IDX_AVAIL: rdata <= AVAIL_MAP;
               usfb_pkg::IDX_CONTROL: rdata <= control;
               usfb_pkg::IDX_ACTIVE: rdata <= active;
               usfb_pkg::IDX_SW_MASK: rdata <= SW_MASK;
               usfb_pkg::IDX_STAT_COUNT: rdata <= usfb_pkg::STAT_COUNT;
               usfb_pkg::IDX_SCALE_STAT: rdata <= scale_stat;
               default: rdata <= 32'h0;
            endcase
         end
      end else begin
         rdata <= 32'h0;
      end
   end

   // step input decode; pins are synchronous so one stage finds edges
   logic a_q;
   logic b_q;
   logic a_rise;
   logic b_rise;
   assign a_rise = step_a & ~a_q;
   assign b_rise = step_b & ~b_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         step_pulse <= 1'b0;
         step_cw <= 1'b1;
      end else begin
         a_q <= step_a;
         b_q <= step_b;
         if (step_mode == usfb_pkg::MODE_CW_CCW) begin
            // simultaneous edges: cw wins, ccw is dropped
            step_pulse <= a_rise | b_rise;
            if (a_rise) begin
               step_cw <= 1'b1;
            end else if (b_rise) begin
               step_cw <= 1'b0;
            end
         end else begin
            step_pulse <= a_rise;
            if (a_rise) begin
               step_cw <= ~step_b;
            end
         end
      end
   end

   // scaling: one mul cycle, then 64 restoring-division steps
   usfb_pkg::usfb_scale_t sc_state;
   logic [63:0] dividend;
   logic [31:0] divisor;
   logic [31:0] rem;
   logic [6:0] step_cnt;
   logic [31:0] sel_num;
   logic [31:0] sel_den;
   logic [32:0] trial;
   logic [1:0] kind_q;
   assign sel_num = num[kind_q];
   assign sel_den = den[kind_q];
   assign trial = {rem, dividend[63]} - {1'b0, divisor};
   assign scale_busy = (sc_state != usfb_pkg::SC_IDLE);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sc_state <= usfb_pkg::SC_IDLE;
         dividend <= 64'h0;
         divisor <= 32'h0;
         rem <= 32'h0;
         step_cnt <= 7'h0;
         kind_q <= 2'h0;
         scale_done <= 1'b0;
         scale_out <= 32'h0;
         scale_err <= 1'b0;
         scale_ovf <= 1'b0;
      end else begin
         scale_done <= 1'b0;
         unique case (sc_state)
            usfb_pkg::SC_IDLE: begin
               if (scale_start && scale_kind != 2'h3) begin
                  kind_q <= scale_kind;
                  dividend <= {32'h0, scale_in};
                  sc_state <= usfb_pkg::SC_MUL;
               end
            end
            usfb_pkg::SC_MUL: begin
               if (sel_den == 32'h0) begin
                  scale_err <= 1'b1;
                  scale_ovf <= 1'b0;
                  scale_out <= 32'h0;
                  scale_done <= 1'b1;
                  sc_state <= usfb_pkg::SC_IDLE;
               end else begin
                  // product kept to 64 bits; huge pole-pair products wrap
                  if (pole_comp == usfb_pkg::COMP_ON) begin
                     dividend <= 64'(dividend[31:0] * sel_num * pole_pairs);
                  end else begin
                     dividend <= 64'(dividend[31:0] * sel_num);
                  end
                  divisor <= sel_den;
                  rem <= 32'h0;
                  step_cnt <= 7'h0;
                  sc_state <= usfb_pkg::SC_DIV;
               end
            end
            usfb_pkg::SC_DIV: begin
               if (!trial[32]) begin
                  rem <= trial[31:0];
                  dividend <= {dividend[62:0], 1'b1};
               end else begin
                  rem <= {rem[30:0], dividend[63]};
                  dividend <= {dividend[62:0], 1'b0};
               end
               step_cnt <= step_cnt + 7'h1;
               if (step_cnt == 7'(usfb_pkg::SCALE_STEPS - 1)) begin
                  scale_out <= {dividend[30:0], ~trial[32]};
                  scale_ovf <= |dividend[62:31];
                  scale_err <= 1'b0;
                  scale_done <= 1'b1;
                  sc_state <= usfb_pkg::SC_IDLE;
               end
            end
         endcase
      end
   end

   // boot delay: compare live so a late write still lengthens the wait
   logic [31:0] ms_cnt;
   logic [$clog2(MS_CYCLES+1)-1:0] tick_cnt;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt <= 32'h0;
         tick_cnt <= '0;
         ready <= 1'b0;
      end else if (!ready) begin
         if (ms_cnt >= boot_delay) begin
            ready <= 1'b1;
         end else if (tick_cnt == $bits(tick_cnt)'(MS_CYCLES - 1)) begin
            tick_cnt <= '0;
            ms_cnt <= ms_cnt + 32'h1;
         end else begin
            tick_cnt <= tick_cnt + $bits(tick_cnt)'(1);
         end
      end
   end

   // reference product for the result check
   logic [63:0] exp_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         exp_q <= 64'h0;
      end else if (sc_state == usfb_pkg::SC_MUL && pole_comp == usfb_pkg::COMP_ON) begin
         exp_q <= 64'(dividend[31:0] * sel_num * pole_pairs);
      end else if (sc_state == usfb_pkg::SC_MUL) begin
         exp_q <= 64'(dividend[31:0] * sel_num);
      end
   end

   sequence s_ctrl_wr;
      wr && idx == usfb_pkg::IDX_CONTROL;
   endsequence
   sequence s_rd_avail;
      rd && idx == usfb_pkg::IDX_AVAIL;
   endsequence
   sequence s_rd_active;
      rd && idx == usfb_pkg::IDX_ACTIVE;
   endsequence

   AST_MODE0_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
      (step_mode == usfb_pkg::MODE_CLK_DIR && a_rise) |=> (step_pulse && step_cw == !$past(step_b)))
      else $error("clock/direction step wrong");
   AST_MODE1_CCW: assert property (@(posedge mclk) disable iff (!rst_n)
      (step_mode == usfb_pkg::MODE_CW_CCW && b_rise && !a_rise) |=> (step_pulse && !step_cw))
      else $error("ccw pulse not decoded");
   AST_COMP_RESET: assert property (@(posedge mclk)
      $rose(rst_n) |-> pole_comp == usfb_pkg::RST_POLE_COMP && den[0] == usfb_pkg::RST_DEN)
      else $error("scale reset values wrong");
   AST_ZERO_DEN: assert property (@(posedge mclk) disable iff (!rst_n)
      (sc_state == usfb_pkg::SC_MUL && sel_den == 32'h0) |=> (scale_done && scale_err))
      else $error("zero denominator not flagged");
   AST_SCALE_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
      (sc_state == usfb_pkg::SC_IDLE && scale_start && scale_kind != 2'h3
         && den[scale_kind] != 32'h0)
      |=> ##1 (!scale_done && scale_busy) [*8] ##[1:60] scale_done)
      else $error("conversion length wrong");
   AST_SCALE_VAL: assert property (@(posedge mclk) disable iff (!rst_n)
      (sc_state == usfb_pkg::SC_MUL && sel_den != 32'h0)
      |-> ##65 (scale_ovf || scale_out == 32'(exp_q / {32'h0, divisor})))
      else $error("conversion result wrong");
   AST_ACTIVE_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
      s_ctrl_wr |=> ((active ^ $past(active)) & ~SW_MASK) == 32'h0)
      else $error("locked bus changed");
   AST_ACTIVE_SW: assert property (@(posedge mclk) disable iff (!rst_n)
      s_ctrl_wr |=> (active & SW_MASK) == ($past(wdata) & SW_LIVE))
      else $error("switchable bus not switched");
   AST_AVAIL_RO: assert property (@(posedge mclk) disable iff (!rst_n)
      s_rd_avail |=> rdata == AVAIL_MAP)
      else $error("availability map read wrong");
   AST_READY_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
      (!ready && ms_cnt < boot_delay) |=> !ready)
      else $error("ready before boot delay");

   AST_MODE1_CW: assert property (@(posedge mclk) disable iff (!rst_n)
      (step_mode == usfb_pkg::MODE_CW_CCW && a_rise) |=> (step_pulse && step_cw))
      else $error("cw pulse not decoded");
   AST_NO_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
      (!a_rise && !b_rise) |=> !step_pulse)
      else $error("step without an edge");
   AST_BUSY_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
      scale_done |-> !scale_busy)
      else $error("busy while result shown");
   AST_CTRL_STORE: assert property (@(posedge mclk) disable iff (!rst_n)
      s_ctrl_wr |=> control == $past(wdata))
      else $error("control write lost");
   AST_ACTIVE_RO: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr && idx == usfb_pkg::IDX_ACTIVE) |=> $stable(active))
      else $error("status entry written");
   AST_ACTIVE_RD: assert property (@(posedge mclk) disable iff (!rst_n)
      s_rd_active |=> rdata == $past(active))
      else $error("active entry read wrong");
   AST_MASK_RD: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd && idx == usfb_pkg::IDX_SW_MASK) |=> rdata == SW_MASK)
      else $error("switchable mask read wrong");
   AST_READY_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      ready |=> ready)
      else $error("ready dropped");
endmodule : usfb_bank
`default_nettype wire

// ===== verif/usfb_bank_test.sv
`default_nettype none
module usfb_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SW_SET = 32'h0000_0041;
   localparam logic [13:0] RIDX [14] = '{usfb_pkg::IDX_STEP_MODE, usfb_pkg::IDX_POLE_COMP,
      usfb_pkg::IDX_VEL_NUM, usfb_pkg::IDX_VEL_DEN, usfb_pkg::IDX_ACC_NUM, usfb_pkg::IDX_ACC_DEN,
      usfb_pkg::IDX_JERK_NUM, usfb_pkg::IDX_JERK_DEN, usfb_pkg::IDX_BOOT_DELAY,
      usfb_pkg::IDX_CONTROL, usfb_pkg::IDX_AVAIL, usfb_pkg::IDX_ACTIVE, usfb_pkg::IDX_SW_MASK,
      usfb_pkg::IDX_STAT_COUNT};
   localparam logic [31:0] RVAL [14] = '{32'h0, 32'h1, 32'h1, 32'h3c, 32'h1, 32'h3c, 32'h1,
      32'h3c, 32'h0, 32'h40, 32'h40, 32'h40, SW_SET, 32'h2};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic step_a = 1'b0;
   logic step_b = 1'b0;
   logic [7:0] pole_pairs = 8'h02;
   logic scale_start = 1'b0;
   logic [1:0] scale_kind = 2'h0;
   logic [31:0] scale_in = 32'h0000_0000;
   logic [31:0] rdata;
   logic [31:0] scale_out;
   logic [31:0] bus_active;
   logic step_pulse;
   logic step_cw;
   logic scale_busy;
   logic scale_done;
   logic scale_err;
   logic scale_ovf;
   logic ready;
   int err_total = 0;
   int check_count = 0;

   always #25 mclk = ~mclk;

   // short millisecond so the boot counter finishes quickly
   usfb_bank #(.MS_CYCLES(4), .SW_MASK(SW_SET)) dut (.mclk(mclk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .step_a(step_a), .step_b(step_b),
      .step_pulse(step_pulse), .step_cw(step_cw), .pole_pairs(pole_pairs),
      .scale_start(scale_start), .scale_kind(scale_kind), .scale_in(scale_in),
      .scale_busy(scale_busy), .scale_done(scale_done), .scale_out(scale_out),
      .scale_err(scale_err), .scale_ovf(scale_ovf), .ready(ready), .bus_active(bus_active));

   task automatic end_sim;
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic timeout(input string msg);
      err_total++;
      $display("unexpected at %0t: no answer for %s", $time, msg);
      end_sim();
   endtask : timeout

   task automatic do_reset;
      resetn <= 1'b0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
   endtask : do_reset

   task automatic reg_wr(input logic [13:0] idx, input logic [31:0] d);
      @(posedge mclk);
      addr <= {idx, 2'b00};
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : reg_wr

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [13:0] idx, output logic [31:0] d);
      @(posedge mclk);
      addr <= {idx, 2'b00};
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   task automatic test_reset;
      logic [31:0] v;
      check(32'(ready), 32'h1, "ready with zero boot delay");
      check(bus_active, 32'h0000_0040, "active port at reset");
      for (int i = 0; i < 14; i++) begin
         reg_rd(RIDX[i], v);
         check(v, RVAL[i], "reset value");
      end
   endtask : test_reset

   task automatic test_rw;
      logic [31:0] v;
      for (int i = 0; i < 9; i++) begin
         reg_wr(RIDX[i], 32'ha5c3_0000 | 32'(i));
      end
      for (int i = 0; i < 9; i++) begin
         reg_rd(RIDX[i], v);
         check(v, 32'ha5c3_0000 | 32'(i), "read back");
      end
      @(posedge mclk);
      #1;
      check(rdata, 32'h0, "read data outside answer cycle");
      reg_wr(usfb_pkg::IDX_AVAIL, 32'hffff_ffff);
      reg_wr(usfb_pkg::IDX_ACTIVE, 32'h0000_0000);
      reg_rd(usfb_pkg::IDX_AVAIL, v);
      check(v, 32'h0000_0040, "availability written");
      reg_rd(usfb_pkg::IDX_ACTIVE, v);
      check(v, 32'h0000_0040, "status written");
      reg_rd(14'h2000, v);
      check(v, 32'h0, "unmapped read");
   endtask : test_rw

   task automatic test_bus;
      logic [31:0] v;
      reg_wr(usfb_pkg::IDX_CONTROL, 32'h0000_0000);
      #1;
      check(bus_active, 32'h0, "switchable bus turned off");
      reg_rd(usfb_pkg::IDX_ACTIVE, v);
      check(v, 32'h0, "status after off");
      // bit 0 is switchable but absent, bit 6 is switchable and present, all others are locked
      reg_wr(usfb_pkg::IDX_CONTROL, 32'hffff_ffff);
      #1;
      check(bus_active, 32'h0000_0040, "only switchable present bus on");
      reg_rd(usfb_pkg::IDX_CONTROL, v);
      check(v, 32'hffff_ffff, "control read back");
      reg_rd(usfb_pkg::IDX_ACTIVE, v);
      check(v, 32'h0000_0040, "status after on");
   endtask : test_bus

   task automatic step_seq(input logic [1:0] lvl0, input logic [1:0] lvl1, input logic exp_cw);
      int n;
      @(posedge mclk);
      {step_a, step_b} <= lvl0;
      repeat (4) @(posedge mclk);
      {step_a, step_b} <= lvl1;
      for (n = 0; n < 6; n++) begin
         @(posedge mclk);
         #1;
         if (step_pulse === 1'b1) break;
      end
      if (n == 6) timeout("step");
      check(32'(step_cw), 32'(exp_cw), "step direction");
      @(posedge mclk);
      #1;
      check(32'(step_pulse), 32'h0, "step pulse length");
   endtask : step_seq

   task automatic test_step;
      reg_wr(usfb_pkg::IDX_STEP_MODE, usfb_pkg::MODE_CLK_DIR);
      step_seq(2'b01, 2'b11, 1'b0);
      step_seq(2'b00, 2'b10, 1'b1);
      // a rising second pin only steps in the two-pulse mode
      reg_wr(usfb_pkg::IDX_STEP_MODE, usfb_pkg::MODE_CW_CCW);
      step_seq(2'b00, 2'b01, 1'b0);
      step_seq(2'b00, 2'b10, 1'b1);
   endtask : test_step

   task automatic scale(input logic [1:0] kind, input logic [31:0] exp, input logic exp_err,
         input logic exp_ovf, input int exp_n);
      int n;
      @(posedge mclk);
      scale_start <= 1'b1;
      scale_kind <= kind;
      scale_in <= 32'h0000_003c;
      @(posedge mclk);
      scale_start <= 1'b0;
      for (n = 1; n < 100; n++) begin
         @(posedge mclk);
         #1;
         if (n == 1) check(32'(scale_busy), 32'(!exp_err), "busy while converting");
         if (scale_done === 1'b1) break;
      end
      if (n == 100) timeout("conversion");
      check(32'(n), 32'(exp_n), "conversion latency");
      check(32'(scale_err), 32'(exp_err), "zero denominator flag");
      check(32'(scale_ovf), 32'(exp_ovf), "overflow flag");
      if (!exp_err) check(scale_out, exp, "scaled value");
   endtask : scale

   task automatic test_scale;
      logic [31:0] v;
      reg_wr(usfb_pkg::IDX_ACC_NUM, 32'h0000_0002);
      reg_wr(usfb_pkg::IDX_JERK_NUM, 32'h0000_0003);
      for (int k = 0; k < 3; k++) begin
         scale(2'(k), 32'(2 * (k + 1)), 1'b0, 1'b0, 65);
      end
      reg_wr(usfb_pkg::IDX_POLE_COMP, 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         scale(2'(k), 32'(k + 1), 1'b0, 1'b0, 65);
      end
      reg_wr(usfb_pkg::IDX_VEL_DEN, 32'h0000_0000);
      scale(2'h0, 32'h0, 1'b1, 1'b0, 1);
      reg_rd(usfb_pkg::IDX_SCALE_STAT, v);
      check(v, 32'h0000_0002, "scale status after error");
      // product beyond 32 bits: low word kept, overflow flagged
      reg_wr(usfb_pkg::IDX_VEL_DEN, 32'h0000_0001);
      reg_wr(usfb_pkg::IDX_VEL_NUM, 32'hffff_ffff);
      scale(2'h0, 32'hffff_ffc4, 1'b0, 1'b1, 65);
      reg_rd(usfb_pkg::IDX_SCALE_STAT, v);
      check(v, 32'h0000_0004, "scale status after overflow");
   endtask : test_scale

   initial begin
      do_reset();
      test_reset();
      test_rw();
      @(posedge mclk);
      do_reset();
      test_reset();
      test_bus();
      test_step();
      test_scale();
      end_sim();
   end
endmodule : usfb_bank_test
`default_nettype wire
